// file: core/epce_engine.sv
// epce_engine: command interpreter of the encoder parameter channel
// assumes: a framer delivers one decoded frame per cmd_valid_i pulse with parity and
// checksum already checked; the host waits for rsp_valid_o before the next frame.
//
// Contract
// - Commands and answers travel on a differential parameter channel apart from analog signals.
// - Position, analog, counter, status, type, reset, address, serial and interface commands decode.
// - Data-field read, store, status, create and key-change commands are supported.
// - The free-memory command returns 128 bytes, or 1792 in the larger variant.
// - Set position, clear counter, set address and configure interface need a matching key.
// - The guard key is 55h after reset until changed by command.
// - Status 00h is reported when no fault is seen.
// - Status 09h flags a parity error and 0Ah a bad frame checksum.
// - Status 0Bh flags an unknown command and 0Dh a disallowed argument.
// - Status 07h flags a watchdog reset from program monitoring.
// - Status 12h flags access to a data field that does not exist.
// - Status 02h flags an invalid internal angular offset at start.
// - Status 1Fh flags a shaft speed too high to form a position.
`timescale 1ns/1ps

module epce_engine
    import epce_pkg::*;
#(
    parameter int          NUM_FIELDS = 8,
    parameter bit          LARGE_MEM  = 1'b0,
    parameter logic [7:0]  TYPE_ID    = 8'h3c,   // arbitrary value
    parameter logic [31:0] SERIAL_VER = 32'h0001_0001 // arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // parameter channel frames
    // decoded by the framer, apart from the analog path
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  cmd_key_i,
    input  wire logic [7:0]  cmd_arg0_i,
    input  wire logic [31:0] cmd_data_i,
    input  wire logic        cmd_parity_err_i,
    input  wire logic        cmd_csum_err_i,
    // fault events from the rest of the encoder
    input  wire logic        wdog_reset_i,
    input  wire logic        offset_bad_i,
    input  wire logic        overspeed_i,
    // position and analog sources
    input  wire logic [31:0] position_i,
    input  wire logic [15:0] analog_i,
    // answer to the framer
    output logic             rsp_valid_o,
    output logic [7:0]       rsp_status_o,
    output logic [31:0]      rsp_data_o,
    // side effects
    output logic             set_pos_o,
    output logic [31:0]      set_pos_value_o,
    output logic             soft_reset_o,
    output logic [7:0]       enc_addr_o,
    output logic [7:0]       iface_cfg_o,
    output logic [7:0]       guard_key_o,
    output logic [7:0]       fault_code_o
);

    epce_state_t state;
    logic [7:0]  cmd;
    logic [7:0]  key;
    logic [7:0]  arg0;
    logic [31:0] data;
    logic        perr;
    logic        cerr;
    logic [31:0] counter;
    logic [7:0]  guard_key;
    logic [7:0]  field_key [NUM_FIELDS];
    logic [31:0] field_mem [NUM_FIELDS];
    logic [NUM_FIELDS-1:0] field_live;
    logic [7:0]  next_status;
    logic [31:0] next_data;
    logic        exec_ok;
    logic [2:0]  slot;

    // known command byte
    function automatic logic is_known(input logic [7:0] c);
        case (c)
            CMD_READ_POS, CMD_SET_POS, CMD_READ_ANALOG, CMD_READ_CNT, CMD_INC_CNT,
            CMD_CLR_CNT, CMD_READ_DATA, CMD_STORE_DATA, CMD_FIELD_STAT, CMD_MAKE_FIELD,
            CMD_FREE_MEM, CMD_CHANGE_KEY, CMD_READ_STAT, CMD_TYPE_LABEL, CMD_RESET,
            CMD_SET_ADDR, CMD_SERIAL_VER, CMD_CFG_IFACE: is_known = 1'b1;
            default: is_known = 1'b0;
        endcase
    endfunction

    // commands that carry the guard key
    function automatic logic needs_key(input logic [7:0] c);
        needs_key = (c == CMD_SET_POS) || (c == CMD_CLR_CNT) ||
                    (c == CMD_SET_ADDR) || (c == CMD_CFG_IFACE);
    endfunction

    function automatic logic is_field_cmd(input logic [7:0] c);
        is_field_cmd = (c == CMD_READ_DATA) || (c == CMD_STORE_DATA) ||
                       (c == CMD_FIELD_STAT) || (c == CMD_CHANGE_KEY);
    endfunction

    function automatic logic field_in_range(input logic [7:0] a);
        field_in_range = (32'(a) < NUM_FIELDS);
    endfunction

    // slot index; only the low bits are decoded, so NUM_FIELDS stays at 8
    function automatic logic [2:0] field_idx(input logic [7:0] a);
        field_idx = a[2:0];
    endfunction

    assign slot = field_idx(arg0);

    ////////////////////////////////////////////////////////////////////////////////
    // frame capture and sequencing; the engine takes one frame at a time,
    // frames arriving outside idle are dropped, the host must wait
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= EPCE_IDLE;
            cmd   <= 8'h00;
            key   <= 8'h00;
            arg0  <= 8'h00;
            data  <= 32'h0000_0000;
            perr  <= 1'b0;
            cerr  <= 1'b0;
        end else begin
            case (state)
                EPCE_IDLE: begin
                    if (cmd_valid_i) begin
                        cmd   <= cmd_code_i;
                        key   <= cmd_key_i;
                        arg0  <= cmd_arg0_i;
                        data  <= cmd_data_i;
                        perr  <= cmd_parity_err_i;
                        cerr  <= cmd_csum_err_i;
                        state <= EPCE_EXEC;
                    end
                end
                EPCE_EXEC: state <= EPCE_RESP;
                EPCE_RESP: state <= EPCE_IDLE;
                default:   state <= EPCE_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode: status byte and answer data
    always_comb begin
        next_status = ST_OK;
        next_data   = 32'h0000_0000;
        if (perr) begin
            next_status = ST_PARITY;
        end else if (cerr) begin
            next_status = ST_CHECKSUM;
        end else if (!is_known(cmd)) begin
            next_status = ST_UNKNOWN_CMD;
        // guard key mismatch is a bad argument
        end else if (needs_key(cmd) && (key != guard_key)) begin
            next_status = ST_BAD_ARG;
        end else if (is_field_cmd(cmd) &&
                     (!field_in_range(arg0) || !field_live[slot])) begin
            next_status = ST_NO_FIELD;
        // field number out of range on create
        end else if ((cmd == CMD_MAKE_FIELD) && !field_in_range(arg0)) begin
            next_status = ST_BAD_ARG;
        end else begin
            case (cmd)
                // live sources are sampled in the exec cycle, not at the take
                CMD_READ_POS:    next_data = position_i;
                CMD_READ_ANALOG: next_data = {16'h0000, analog_i};
                CMD_READ_CNT:    next_data = counter;
                CMD_INC_CNT:     next_data = counter + 32'h0000_0001;
                CMD_READ_DATA:   next_data = field_mem[slot];
                CMD_FIELD_STAT:  next_data = {24'h00_0000, field_key[slot]};
                CMD_FREE_MEM:    next_data = {16'h0000,
                                              LARGE_MEM ? FREE_MEM_LARGE : FREE_MEM_SMALL};
                CMD_READ_STAT:   next_data = {24'h00_0000, fault_code_o};
                CMD_TYPE_LABEL:  next_data = {24'h00_0000, TYPE_ID};
                CMD_SERIAL_VER:  next_data = SERIAL_VER;
                default:         next_data = 32'h0000_0000;
            endcase
        end
    end

    assign exec_ok = (state == EPCE_EXEC) && (next_status == ST_OK);

    ////////////////////////////////////////////////////////////////////////////////
    // answer registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_o  <= 1'b0;
            rsp_status_o <= ST_OK;
            rsp_data_o   <= 32'h0000_0000;
        end else begin
            rsp_valid_o <= (state == EPCE_EXEC);
            // status and data hold until the next answer
            if (state == EPCE_EXEC) begin
                rsp_status_o <= next_status;
                rsp_data_o   <= next_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault hold; reads 00h until a fault occurs
    // sticky: a clean command never clears it; events beat command errors
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_code_o <= ST_OK;
        end else if (wdog_reset_i) begin
            fault_code_o <= ST_WDOG_RESET;
        end else if (offset_bad_i) begin
            fault_code_o <= ST_BAD_OFFSET;
        end else if (overspeed_i) begin
            fault_code_o <= ST_OVERSPEED;
        end else if ((state == EPCE_EXEC) && (next_status != ST_OK)) begin
            fault_code_o <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter
    // wraps silently at all ones, no overflow status is kept
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            counter <= COUNTER_RST;
        end else if (exec_ok && (cmd == CMD_INC_CNT)) begin
            counter <= counter + 32'h0000_0001;
        end else if (exec_ok && (cmd == CMD_CLR_CNT)) begin
            counter <= COUNTER_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // keyed configuration and one-cycle side effects
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            guard_key       <= GUARD_KEY_RST;
            enc_addr_o      <= ADDR_RST;
            iface_cfg_o     <= IFACE_CFG_RST;
            set_pos_o       <= 1'b0;
            set_pos_value_o <= 32'h0000_0000;
            soft_reset_o    <= 1'b0;
        end else begin
            set_pos_o    <= exec_ok && (cmd == CMD_SET_POS);
            soft_reset_o <= exec_ok && (cmd == CMD_RESET);
            if (exec_ok && (cmd == CMD_SET_POS)) begin
                set_pos_value_o <= data;
            end
            if (exec_ok && (cmd == CMD_SET_ADDR)) begin
                enc_addr_o <= data[7:0];
            end
            if (exec_ok && (cmd == CMD_CFG_IFACE)) begin
                iface_cfg_o <= data[7:0];
            end
            // key change on field 0 also changes the guard key
            // needs the current field-0 key, as the field change does
            if (exec_ok && (cmd == CMD_CHANGE_KEY) && (arg0 == 8'h00) &&
                (key == field_key[0])) begin
                guard_key <= data[7:0];
            end
        end
    end

    assign guard_key_o = guard_key;

    ////////////////////////////////////////////////////////////////////////////////
    // data fields; small register array, one word each
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            field_live <= '0;
            for (int i = 0; i < NUM_FIELDS; i++) begin
                field_key[i] <= GUARD_KEY_RST;
                field_mem[i] <= 32'h0000_0000;
            end
        end else if (exec_ok) begin
            case (cmd)
                CMD_MAKE_FIELD: begin
                    field_live[slot] <= 1'b1;
                    field_mem[slot]  <= 32'h0000_0000;
                end
                CMD_STORE_DATA: begin
                    field_mem[slot] <= data;
                end
                CMD_CHANGE_KEY: begin
                    if (key == field_key[slot]) begin
                        field_key[slot] <= data[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

endmodule // epce_engine

// file: core/epce_pkg.sv
// epce_pkg: command codes, status codes and defaults of the parameter command engine
// assumes: byte framing and parity/checksum checking are done by the caller
package epce_pkg;

    // command bytes
    localparam logic [7:0] CMD_READ_POS    = 8'h42;
    localparam logic [7:0] CMD_SET_POS     = 8'h43;
    localparam logic [7:0] CMD_READ_ANALOG = 8'h44;
    localparam logic [7:0] CMD_READ_CNT    = 8'h46;
    localparam logic [7:0] CMD_INC_CNT     = 8'h47;
    localparam logic [7:0] CMD_CLR_CNT     = 8'h49;
    localparam logic [7:0] CMD_READ_DATA   = 8'h4a;
    localparam logic [7:0] CMD_STORE_DATA  = 8'h4b;
    localparam logic [7:0] CMD_FIELD_STAT  = 8'h4c;
    localparam logic [7:0] CMD_MAKE_FIELD  = 8'h4d;
    localparam logic [7:0] CMD_FREE_MEM    = 8'h4e;
    localparam logic [7:0] CMD_CHANGE_KEY  = 8'h4f;
    localparam logic [7:0] CMD_READ_STAT   = 8'h50;
    localparam logic [7:0] CMD_TYPE_LABEL  = 8'h52;
    localparam logic [7:0] CMD_RESET       = 8'h53;
    localparam logic [7:0] CMD_SET_ADDR    = 8'h55;
    localparam logic [7:0] CMD_SERIAL_VER  = 8'h56;
    localparam logic [7:0] CMD_CFG_IFACE   = 8'h57;

    // status codes
    localparam logic [7:0] ST_OK          = 8'h00;
    localparam logic [7:0] ST_BAD_OFFSET  = 8'h02;
    localparam logic [7:0] ST_WDOG_RESET  = 8'h07;
    localparam logic [7:0] ST_PARITY      = 8'h09;
    localparam logic [7:0] ST_CHECKSUM    = 8'h0a;
    localparam logic [7:0] ST_UNKNOWN_CMD = 8'h0b;
    localparam logic [7:0] ST_BAD_ARG     = 8'h0d;
    localparam logic [7:0] ST_NO_FIELD    = 8'h12;
    localparam logic [7:0] ST_OVERSPEED   = 8'h1f;

    // reset values and free-memory sizes
    localparam logic [7:0]  GUARD_KEY_RST = 8'h55;
    localparam logic [7:0]  ADDR_RST      = 8'h40;
    localparam logic [7:0]  IFACE_CFG_RST = 8'he4;
    localparam logic [31:0] COUNTER_RST   = 32'h0000_0000;
    localparam logic [15:0] FREE_MEM_SMALL = 16'h0080;
    localparam logic [15:0] FREE_MEM_LARGE = 16'h0700;

    typedef enum logic [1:0] {
        EPCE_IDLE = 2'b00,
        EPCE_EXEC = 2'b01,
        EPCE_RESP = 2'b11
    } epce_state_t;

endpackage : epce_pkg

// file: test/epce_engine_chk_chk.sv
// epce_engine_chk: answer timing and status code checks on the engine ports
// assumes: bound into epce_engine, one clock domain
`timescale 1ns/1ps

module epce_engine_chk
    import epce_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_key_i,
    input wire logic       cmd_parity_err_i,
    input wire logic       cmd_csum_err_i,
    input wire logic       wdog_reset_i,
    input wire logic       offset_bad_i,
    input wire logic       overspeed_i,
    input wire logic       rsp_valid_o,
    input wire logic [7:0] rsp_status_o,
    input wire logic       set_pos_o,
    input wire logic       soft_reset_o,
    input wire logic [7:0] guard_key_o,
    input wire logic [7:0] fault_code_o
);
    logic [1:0] busy;
    logic       take;
    logic       clean;
    assign take  = cmd_valid_i && busy == 2'h0;
    assign clean = take && !cmd_parity_err_i && !cmd_csum_err_i;
    // frames offered while busy are dropped, so mirror the busy window
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) busy <= 2'h0;
        else if (take) busy <= 2'h2;
        else if (busy != 2'h0) busy <= busy - 2'h1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_answer;
        ##2 rsp_valid_o;
    endsequence
    sequence s_status(logic [7:0] code);
        ##2 (rsp_valid_o && rsp_status_o == code);
    endsequence

    a_answer_two_cycles: assert property (take |-> s_answer)
        else $error("answer not two cycles after take");
    a_answer_one_pulse: assert property (rsp_valid_o |=> !rsp_valid_o [*2])
        else $error("answer pulse too long");
    a_answer_has_cause: assert property (rsp_valid_o |-> $past(take, 2))
        else $error("answer without a frame");
    a_parity_first: assert property (take && cmd_parity_err_i |-> s_status(ST_PARITY))
        else $error("parity status wrong");
    a_csum_second: assert property (take && !cmd_parity_err_i && cmd_csum_err_i |->
        s_status(ST_CHECKSUM))
        else $error("checksum status wrong");
    a_unknown_code: assert property (clean && !(cmd_code_i inside {[8'h42:8'h57]}) |->
        s_status(ST_UNKNOWN_CMD))
        else $error("unknown command not flagged");
    a_key_guard: assert property (clean && cmd_key_i != guard_key_o
        && cmd_code_i inside {8'h43, 8'h49, 8'h55, 8'h57}
        |-> s_status(ST_BAD_ARG) ##0 !set_pos_o)
        else $error("bad key accepted");
    a_pulse_paired: assert property (set_pos_o || soft_reset_o |-> rsp_valid_o)
        else $error("side pulse off the answer");
    a_key_moves: assert property ($changed(guard_key_o) |-> rsp_valid_o)
        else $error("guard key changed without a command");
    a_wdog_code: assert property (wdog_reset_i |=> fault_code_o == ST_WDOG_RESET)
        else $error("watchdog event lost");
    a_offset_code: assert property (offset_bad_i && !wdog_reset_i |->
        ##1 fault_code_o == ST_BAD_OFFSET)
        else $error("offset fault lost");
    a_speed_code: assert property (overspeed_i && !wdog_reset_i && !offset_bad_i |->
        ##1 fault_code_o == ST_OVERSPEED)
        else $error("overspeed fault lost");
endmodule // epce_engine_chk

// file: test/epce_host_model.sv
// epce_host_model: drive-side framer that hands decoded frames to the engine
// assumes: inputs change at falling edges, one frame in flight at a time
`timescale 1ns/1ps

module epce_host_model (
    input  wire logic   clk_i,
    input  wire logic   rsp_valid_i,
    output logic        cmd_valid_o,
    output logic [7:0]  cmd_code_o,
    output logic [7:0]  cmd_key_o,
    output logic [7:0]  cmd_arg0_o,
    output logic [31:0] cmd_data_o,
    output logic        cmd_parity_err_o,
    output logic        cmd_csum_err_o,
    output logic        timed_out_o
);
    initial begin
        {cmd_valid_o, cmd_code_o, cmd_key_o, cmd_arg0_o, cmd_data_o} = '0;
        {cmd_parity_err_o, cmd_csum_err_o, timed_out_o} = '0;
    end

    task automatic send(input logic [7:0] c, k, a, input logic [31:0] d, input logic pe, ce);
        int n;
        @(negedge clk_i);
        {cmd_code_o, cmd_key_o, cmd_arg0_o, cmd_data_o} = {c, k, a, d};
        {cmd_parity_err_o, cmd_csum_err_o} = {pe, ce};
        cmd_valid_o = 1'b1;
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        // fields are not held past the take, so scramble them
        {cmd_code_o, cmd_key_o, cmd_arg0_o, cmd_data_o} = ~{c, k, a, d};
        {cmd_parity_err_o, cmd_csum_err_o} = ~{pe, ce};
        n = 0;
        while (!rsp_valid_i && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        timed_out_o = (n == 8);
    endtask
endmodule // epce_host_model

// file: test/tb_top.sv
// tb_top: command sequences with expected answers for the parameter command engine
// assumes: epce_pkg compiled first, host model and checker files present
`timescale 1ns/1ps

module tb_top;
    import epce_pkg::*;
    localparam logic [7:0]  TID  = 8'h5a;        // arbitrary value
    localparam logic [31:0] SVER = 32'h0002_0003; // arbitrary value
    logic        clk = 1'b0, rst_b = 1'b0, wdog = 1'b0, offs = 1'b0, ovsp = 1'b0;
    logic        cv, pe, ce, to, rv, sp, sr, saw_rst = 1'b0;
    logic [7:0]  code, key, arg, st, addr, cfg, gkey, fault;
    logic [31:0] dat, rdat, spv, pos = 32'h1234_5678;
    int          fail_count = 0, samples_checked = 0;
    logic [7:0]  codes [18] = '{8'h42, 8'h43, 8'h44, 8'h46, 8'h47, 8'h49, 8'h4a, 8'h4b,
        8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h52, 8'h53, 8'h55, 8'h56, 8'h57};
    logic [7:0]  fcode [3] = '{8'h07, 8'h02, 8'h1f};

    always #2 clk = ~clk;
    always @(posedge clk) if (sr) saw_rst <= 1'b1;

    epce_host_model epce_host_model_i (.clk_i(clk), .rsp_valid_i(rv), .cmd_valid_o(cv),
        .cmd_code_o(code), .cmd_key_o(key), .cmd_arg0_o(arg), .cmd_data_o(dat),
        .cmd_parity_err_o(pe), .cmd_csum_err_o(ce), .timed_out_o(to));
    epce_engine #(.TYPE_ID(TID), .SERIAL_VER(SVER)) epce_engine_i (.clk_i(clk),
        .rst_b_i(rst_b), .cmd_valid_i(cv), .cmd_code_i(code), .cmd_key_i(key),
        .cmd_arg0_i(arg), .cmd_data_i(dat), .cmd_parity_err_i(pe), .cmd_csum_err_i(ce),
        .wdog_reset_i(wdog), .offset_bad_i(offs), .overspeed_i(ovsp),
        .position_i(pos), .analog_i(16'h0a5c), .rsp_valid_o(rv),
        .rsp_status_o(st), .rsp_data_o(rdat), .set_pos_o(sp), .set_pos_value_o(spv),
        .soft_reset_o(sr), .enc_addr_o(addr), .iface_cfg_o(cfg), .guard_key_o(gkey),
        .fault_code_o(fault));

    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input logic [7:0] c, k, a, input logic [31:0] d,
                       input logic p, s, input logic [7:0] exp);
        epce_host_model_i.send(c, k, a, d, p, s);
        chk("timeout", to, 1'b0);
        chk("status", st, exp);
    endtask
    function automatic logic [31:0] exp_data(input logic [7:0] c);
        case (c)
            8'h42: return 32'h1234_5678;
            8'h44: return 32'h0000_0a5c;
            8'h47: return 32'h1;
            8'h4e: return 32'h80;
            8'h50: return 32'h12; // last fault was the missing field
            8'h52: return {24'h0, TID};
            8'h56: return SVER;
            default: return 32'h0;
        endcase
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        chk("guard key", gkey, 8'h55);
        chk("address", {addr, cfg}, 16'h40e4);
        chk("idle status", {st, fault}, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 18; i++) begin
            run(codes[i], 8'h55, 8'h0, 32'h55, 1'b0, 1'b0, (i inside {[6:8]}) ? 8'h12 : 8'h0);
            if (st === 8'h00) chk("data", rdat, exp_data(codes[i]));
        end
        chk("addr cfg pos", {addr, cfg, spv[15:0]}, 32'h5555_0055);
        chk("soft reset", saw_rst, 1'b1);
        run(8'h4b, 8'h55, 8'h0, 32'hcafe_f00d, 1'b0, 1'b0, 8'h00);
        run(8'h4a, 8'h55, 8'h0, 32'h0, 1'b0, 1'b0, 8'h00);
        chk("field word", rdat, 32'hcafe_f00d);
        $display("test command table done");
        run(8'h41, 8'h55, 8'h0, 32'h0, 1'b1, 1'b1, 8'h09);
        run(8'h41, 8'h55, 8'h0, 32'h0, 1'b0, 1'b1, 8'h0a);
        run(8'h41, 8'h55, 8'h0, 32'h0, 1'b0, 1'b0, 8'h0b);
        run(8'h55, 8'h12, 8'h0, 32'h77, 1'b0, 1'b0, 8'h0d);
        chk("kept address", addr, 8'h55);
        run(8'h4d, 8'h55, 8'h8, 32'h0, 1'b0, 1'b0, 8'h0d);
        run(8'h4a, 8'h55, 8'h9, 32'h0, 1'b0, 1'b0, 8'h12);
        run(8'h50, 8'h55, 8'h0, 32'h0, 1'b0, 1'b0, 8'h00);
        chk("held fault", rdat, 32'h12);
        $display("test error codes done");
        for (int j = 0; j < 3; j++) begin
            @(negedge clk);
            {wdog, offs, ovsp} = 3'b100 >> j;
            @(negedge clk);
            {wdog, offs, ovsp} = 3'b000;
            run(8'h50, 8'h55, 8'h0, 32'h0, 1'b0, 1'b0, 8'h00);
            chk("event fault", rdat, {24'h0, fcode[j]});
        end
        $display("test fault events done");
        run(8'h4f, 8'h55, 8'h0, 32'h33, 1'b0, 1'b0, 8'h00);
        chk("new guard key", gkey, 8'h33);
        run(8'h43, 8'h55, 8'h0, 32'h99, 1'b0, 1'b0, 8'h0d);
        chk("no set pulse", sp, 1'b0);
        run(8'h43, 8'h33, 8'h0, 32'h99, 1'b0, 1'b0, 8'h00);
        chk("set position", spv, 32'h99);
        chk("set pulse", sp, 1'b1);
        pos = 32'h0fed_cba9;
        run(8'h42, 8'h33, 8'h0, 32'h0, 1'b0, 1'b0, 8'h00);
        chk("new position", rdat, 32'h0fed_cba9);
        $display("test key change done");
        conclude();
    end
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
endmodule // tb_top

bind epce_engine epce_engine_chk epce_engine_chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_key_i(cmd_key_i),
    .cmd_parity_err_i(cmd_parity_err_i), .cmd_csum_err_i(cmd_csum_err_i),
    .wdog_reset_i(wdog_reset_i), .rsp_valid_o(rsp_valid_o), .rsp_status_o(rsp_status_o),
    .set_pos_o(set_pos_o), .soft_reset_o(soft_reset_o), .guard_key_o(guard_key_o),
    .offset_bad_i(offset_bad_i), .overspeed_i(overspeed_i), .fault_code_o(fault_code_o));
